// ===== hw/rss_params.svh
// Constants of the reset source sequencer
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH
`define RSS_CNT_W       12
`define RSS_LONG_CYC    4096
`define RSS_SHORT_CYC   64
`define RSS_TAIL_CYC    3
`define RSS_SSTOP_CYC   32
`define RSS_TICK_CYC    4080
`define RSS_CLK_PS      5000
`define RSS_PIN_MIN_NS  50
`define RSS_PIN_MIN_CYC ((`RSS_PIN_MIN_NS * 1000 + `RSS_CLK_PS - 1) / `RSS_CLK_PS)
`define RSS_WD_W        7
`define RSS_VEC_USER    16'hfffe
`define RSS_VEC_MON     16'hfefe
`define RSS_ERASED      8'h00
`define RSS_A_CAUSE     16'hfe00
`define RSS_A_OPT       16'hfe01
`define RSS_A_CNT_LO    16'hfe02
`define RSS_A_CNT_HI    16'hfe03
`define RSS_A_SERVICE   16'hffff
`define RSS_B_POR       7
`define RSS_B_PIN       6
`define RSS_B_WD        5
`define RSS_B_BADOP     4
`define RSS_B_BADADR    3
`define RSS_B_ERASED    2
`define RSS_B_LV        1
`define RSS_O_STOPEN    0
`define RSS_O_SHORT_STOP_RECOVERY     1
`define RSS_O_LVPWR     2
`define RSS_O_LVRST     3
`define RSS_OPT_MASK    8'h0f
`define RSS_CAUSE_RST   8'h00
`define RSS_OPT_RST     8'h00
`endif

// ===== hw/rss_pkg.sv
// Types of the reset source sequencer
package rss_pkg;
	`include "rss_params.svh"
	typedef enum logic [2:0] {
		ST_HOLD,
		ST_LONG,
		ST_SHORT,
		ST_RUN,
		ST_STOP,
		ST_SREC
	} rss_state_e;
	typedef struct packed {
		rss_state_e            state;
		logic [`RSS_CNT_W-1:0] cnt;
		logic [6:0]            rec;
		logic                  long_f;
		logic [`RSS_WD_W-1:0]  wd_cnt;
		logic                  wd_tick;
		logic                  pin_s1;
		logic                  pin_s2;
		logic [3:0]            pin_cnt;
		logic [7:0]            cause;
		logic [7:0]            opt;
		logic [7:0]            rdata;
		logic                  internal_reset_n_n;
		logic                  cpu_en;
		logic                  cgen_en;
		logic                  force_mon;
		logic [15:0]           vec;
	} rss_state_s;
endpackage : rss_pkg

// ===== hw/rss_reset_sequencer.sv
// Reset sequencer, reset cause register, system counter and watchdog
//
// Behaviour
// - Every reset asserts reset, selects reset vector
// - Registers and modules return to defaults
// - Each cause clears counter, sets cause bit
// - Low reset pin halts; long low sets flag
// - Power/low-voltage: 4096 hold then 67 phase
// - Recovery 4163 cycles long, 67 otherwise
// - Watchdog request accepted regardless of bus phase
// - Enable clock generator; core clocks wait 4096 in long recovery
// - Power-on sets its bit, clears others
// - Watchdog overflow resets, sets watchdog bit
// - Service write clears watchdog, counter bits 11:4
// - Counter tick at least every 4080 cycles
// - Watchdog disabled only by monitor high voltage
// - Illegal instruction sets flag and resets
// - Stop with stop disabled is illegal opcode
// - Unmapped opcode fetch resets; data access not
// - Erased reset vector resets, forces monitor mode
// - Low voltage resets unless disabled; holds, recovers
// - Twelve-bit counter on falling clock edge
// - Stop clears counter; wake after 4096 or 32
// - Counter runs freely after recovery
`timescale 1ns/10ps
module rss_reset_sequencer
	import rss_pkg::*;
#(
	parameter int WD_TICKS = 64
) (
	input  wire logic        REF_CLK_I,
	input  wire logic        RESETN_I,
	input  wire logic        POWER_ON_PULSE_I,
	input  wire logic        EXT_RESET_N_I,
	input  wire logic        LOW_VOLTAGE_I,
	input  wire logic        ILLEGAL_OPCODE_I,
	input  wire logic        STOP_EXEC_I,
	input  wire logic        WAKE_I,
	input  wire logic        OPCODE_FETCH_I,
	input  wire logic        UNMAPPED_ADDR_I,
	input  wire logic        VECTOR_FETCH_I,
	input  wire logic [7:0]  VECTOR_DATA_I,
	input  wire logic        MONITOR_MODE_I,
	input  wire logic        IRQ_HIGH_VOLTAGE_I,
	input  wire logic [15:0] ADDR_I,
	input  wire logic [7:0]  WDATA_I,
	input  wire logic        WR_I,
	input  wire logic        RD_I,
	output logic      [7:0]  RDATA_O,
	output logic             INTERNAL_RESET_N_O,
	output logic             CPU_CLK_EN_O,
	output logic             CLOCK_GENERATOR_OUTPUT_EN_O,
	output logic      [15:0] RESET_VECTOR_O,
	output logic             FORCE_MONITOR_O
);

	localparam logic [3:0] PIN_LAST = 4'(`RSS_PIN_MIN_CYC - 1);
	localparam logic [`RSS_CNT_W-1:0] LONG_LAST = 12'(`RSS_LONG_CYC - 1);
	localparam logic [`RSS_CNT_W-1:0] SSTOP_LAST = 12'(`RSS_SSTOP_CYC - 1);
	localparam logic [`RSS_CNT_W-1:0] TICK_LAST = 12'(`RSS_TICK_CYC - 1);
	localparam logic [6:0] SHORT_LAST = 7'(`RSS_SHORT_CYC + `RSS_TAIL_CYC - 1);
	localparam logic [`RSS_WD_W-1:0] WD_LAST = 7'(WD_TICKS - 1);

	// Full long recovery after the block's own reset, as after power-up
	localparam rss_state_s RST_VAL = '{
		state: ST_HOLD, cnt: 12'h000, rec: 7'h00, long_f: 1'b1,
		wd_cnt: 7'h00, wd_tick: 1'b0, pin_s1: 1'b1, pin_s2: 1'b1,
		pin_cnt: 4'h0, cause: `RSS_CAUSE_RST, opt: `RSS_OPT_RST,
		rdata: 8'h00, internal_reset_n_n: 1'b0, cpu_en: 1'b0, cgen_en: 1'b0,
		force_mon: 1'b0, vec: `RSS_VEC_USER
	};

	function automatic logic [7:0] bm(input int pos);
		bm = 8'h01 << pos;
	endfunction : bm

	rss_state_s q;
	rss_state_s d;

	logic pin_low;
	logic lv_trip;
	logic run;
	logic in_rst;
	logic svc;
	logic wd_en;
	logic wd_ovf;
	logic bad_op;
	logic bad_adr;
	logic erased;
	logic hold_c;
	logic pulse_c;

	assign pin_low = !q.pin_s2;
	assign lv_trip = LOW_VOLTAGE_I && !q.opt[`RSS_O_LVPWR] && !q.opt[`RSS_O_LVRST];
	assign run     = q.state == ST_RUN;
	assign in_rst  = q.state inside {ST_HOLD, ST_LONG, ST_SHORT};
	assign svc     = run && WR_I && ADDR_I == `RSS_A_SERVICE;
	// Purely combinational so a glitch cannot latch the watchdog off
	assign wd_en   = !(MONITOR_MODE_I && IRQ_HIGH_VOLTAGE_I);
	// Taken on any clock, not only on bus-clock phases
	assign wd_ovf  = run && wd_en && q.wd_tick && q.wd_cnt == WD_LAST;
	assign bad_op  = run && (ILLEGAL_OPCODE_I || (STOP_EXEC_I && !q.opt[`RSS_O_STOPEN]));
	assign bad_adr = run && OPCODE_FETCH_I && UNMAPPED_ADDR_I;
	assign erased  = run && VECTOR_FETCH_I && VECTOR_DATA_I == `RSS_ERASED;
	assign hold_c  = POWER_ON_PULSE_I || lv_trip || pin_low;
	assign pulse_c = wd_ovf || bad_op || bad_adr || erased;

	always_comb begin
		d = q;
		d.pin_s1 = EXT_RESET_N_I;
		d.pin_s2 = q.pin_s1;
		d.rdata = 8'h00;
		d.wd_tick = 1'b0;
		d.cgen_en = 1'b1;
		if (pin_low) begin
			if (q.pin_cnt != PIN_LAST) begin
				d.pin_cnt = q.pin_cnt + 4'h1;
			end
		end else begin
			d.pin_cnt = 4'h0;
		end
		if (POWER_ON_PULSE_I) begin
			d.cause = bm(`RSS_B_POR);
		end else begin
			if (pin_low && q.pin_cnt == PIN_LAST) begin
				d.cause = d.cause | bm(`RSS_B_PIN);
			end
			if (lv_trip) begin
				d.cause = d.cause | bm(`RSS_B_LV);
			end
			if (wd_ovf) begin
				d.cause = d.cause | bm(`RSS_B_WD);
			end
			if (bad_op) begin
				d.cause = d.cause | bm(`RSS_B_BADOP);
			end
			if (bad_adr) begin
				d.cause = d.cause | bm(`RSS_B_BADADR);
			end
			if (erased) begin
				d.cause = d.cause | bm(`RSS_B_ERASED);
			end
		end
		if (POWER_ON_PULSE_I) begin
			d.force_mon = 1'b0;
		end else if (erased) begin
			d.force_mon = 1'b1;
		end
		if (in_rst) begin
			d.opt = `RSS_OPT_RST;
			d.wd_cnt = 7'h00;
		end else if (run && WR_I && ADDR_I == `RSS_A_OPT) begin
			d.opt = WDATA_I & `RSS_OPT_MASK;
		end
		if (RD_I) begin
			unique case (ADDR_I)
				`RSS_A_CAUSE: d.rdata = q.cause;
				`RSS_A_OPT: d.rdata = q.opt;
				`RSS_A_CNT_LO: d.rdata = q.cnt[7:0];
				`RSS_A_CNT_HI: d.rdata = {q.internal_reset_n_n, q.cpu_en, q.force_mon, 1'b0, q.cnt[11:8]};
				default: d.rdata = 8'h00;
			endcase
		end
		if (hold_c) begin
			d.state = ST_HOLD;
			d.cnt = 12'h000;
			d.long_f = q.long_f || POWER_ON_PULSE_I || lv_trip;
		end else if (pulse_c) begin
			d.state = ST_SHORT;
			d.cnt = 12'h000;
			d.rec = 7'h00;
			d.long_f = 1'b0;
		end else begin
			unique case (q.state)
				ST_HOLD: begin
					d.state = q.long_f ? ST_LONG : ST_SHORT;
					d.rec = 7'h00;
				end
				ST_LONG: begin
					d.cnt = q.cnt + 12'h001;
					if (q.cnt == LONG_LAST) begin
						d.state = ST_SHORT;
						d.long_f = 1'b0;
					end
				end
				ST_SHORT: begin
					d.cnt = q.cnt + 12'h001;
					d.rec = q.rec + 7'h01;
					if (q.rec == SHORT_LAST) begin
						d.state = ST_RUN;
					end
				end
				ST_RUN: begin
					// Early wrap keeps the watchdog tick within its period
					d.cnt = (q.cnt == TICK_LAST) ? 12'h000 : q.cnt + 12'h001;
					d.wd_tick = q.cnt == TICK_LAST;
					if (q.wd_tick && wd_en) begin
						d.wd_cnt = q.wd_cnt + 7'h01;
					end
					if (svc) begin
						d.wd_cnt = 7'h00;
						d.cnt[11:4] = 8'h00;
						d.wd_tick = 1'b0;
					end
					if (STOP_EXEC_I) begin
						d.state = ST_STOP;
						d.cnt = 12'h000;
						d.wd_tick = 1'b0;
					end
				end
				ST_STOP: begin
					if (WAKE_I) begin
						d.state = ST_SREC;
					end
				end
				ST_SREC: begin
					d.cnt = q.cnt + 12'h001;
					if (q.cnt == (q.opt[`RSS_O_SHORT_STOP_RECOVERY] ? SSTOP_LAST : LONG_LAST)) begin
						d.state = ST_RUN;
					end
				end
			endcase
		end
		d.internal_reset_n_n = d.state inside {ST_RUN, ST_STOP, ST_SREC};
		d.cpu_en = d.state inside {ST_SHORT, ST_RUN};
		d.vec = (MONITOR_MODE_I || d.force_mon) ? `RSS_VEC_MON : `RSS_VEC_USER;
	end

	// Falling edge of the selected clock drives every register
	always_ff @(negedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			q <= RST_VAL;
		end else begin
			q <= d;
		end
	end

	assign RDATA_O = q.rdata;
	assign INTERNAL_RESET_N_O = q.internal_reset_n_n;
	assign CPU_CLK_EN_O = q.cpu_en;
	assign CLOCK_GENERATOR_OUTPUT_EN_O = q.cgen_en;
	assign RESET_VECTOR_O = q.vec;
	assign FORCE_MONITOR_O = q.force_mon;

	// Recovery length tracker for the checks below
	logic [12:0] hlp_n;
	logic [1:0]  hlp_k;
	always_ff @(negedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			hlp_n <= 13'h0000;
			hlp_k <= 2'h0;
		end else begin
			if (q.state inside {ST_HOLD, ST_STOP, ST_RUN}) begin
				hlp_n <= 13'h0000;
				hlp_k <= (q.state == ST_STOP) ? 2'h2 : 2'h0;
			end else begin
				hlp_n <= hlp_n + 13'h0001;
				if (q.state == ST_LONG) begin
					hlp_k <= 2'h1;
				end
			end
		end
	end

	default clocking cb @(negedge REF_CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	property p_vector;
		RESET_VECTOR_O == (($past(MONITOR_MODE_I) || FORCE_MONITOR_O) ? `RSS_VEC_MON : `RSS_VEC_USER);
	endproperty
	a_vector: assert property (p_vector) else $error("reset vector wrong");

	property p_opt_clear;
		q.state == ST_LONG |-> q.opt == `RSS_OPT_RST && !INTERNAL_RESET_N_O;
	endproperty
	a_opt_clear: assert property (p_opt_clear) else $error("options kept in reset");

	property p_cause_clr;
		pulse_c && !hold_c |=> q.cnt == 12'h000 && !INTERNAL_RESET_N_O && q.state == ST_SHORT;
	endproperty
	a_cause_clr: assert property (p_cause_clr) else $error("cause did not clear counter");

	property p_pin;
		!EXT_RESET_N_I [*4] |-> !INTERNAL_RESET_N_O && !CPU_CLK_EN_O;
	endproperty
	a_pin: assert property (p_pin) else $error("pin low did not halt");

	property p_long;
		$rose(q.state == ST_SHORT) && hlp_k == 2'h1 |-> hlp_n == 13'(`RSS_LONG_CYC);
	endproperty
	a_long: assert property (p_long) else $error("long hold length wrong");

	property p_recovery;
		$rose(q.state == ST_RUN) && hlp_k != 2'h2 |-> hlp_n == ((hlp_k == 2'h1) ?
			13'(`RSS_LONG_CYC + `RSS_SHORT_CYC + `RSS_TAIL_CYC) : 13'(`RSS_SHORT_CYC + `RSS_TAIL_CYC));
	endproperty
	a_recovery: assert property (p_recovery) else $error("recovery length wrong");

	property p_clk_gate;
		q.state == ST_LONG |-> !CPU_CLK_EN_O ##1 CLOCK_GENERATOR_OUTPUT_EN_O;
	endproperty
	a_clk_gate: assert property (p_clk_gate) else $error("core clocks active too early");

	property p_por;
		POWER_ON_PULSE_I |=> q.cause == bm(`RSS_B_POR) && !INTERNAL_RESET_N_O;
	endproperty
	a_por: assert property (p_por) else $error("power-on cause wrong");

	property p_wd;
		wd_ovf && !hold_c |=> q.cause[`RSS_B_WD] && !INTERNAL_RESET_N_O;
	endproperty
	a_wd: assert property (p_wd) else $error("watchdog overflow not reset");

	property p_svc;
		svc && !hold_c && !pulse_c && !STOP_EXEC_I |=> q.wd_cnt == 7'h00 && q.cnt[11:4] == 8'h00;
	endproperty
	a_svc: assert property (p_svc) else $error("service write not honoured");

	property p_tick;
		q.state == ST_RUN |-> q.cnt <= TICK_LAST;
	endproperty
	a_tick: assert property (p_tick) else $error("counter passed tick period");

	property p_wd_dis;
		run && !wd_en && !svc && !hold_c && !pulse_c && !STOP_EXEC_I |=> q.wd_cnt == $past(q.wd_cnt);
	endproperty
	a_wd_dis: assert property (p_wd_dis) else $error("watchdog counted while disabled");

	property p_badop;
		bad_op && !hold_c |=> q.cause[`RSS_B_BADOP] ##1 !INTERNAL_RESET_N_O;
	endproperty
	a_badop: assert property (p_badop) else $error("illegal opcode not reset");

	property p_badadr;
		bad_adr && !hold_c |=> q.cause[`RSS_B_BADADR] && q.state == ST_SHORT;
	endproperty
	a_badadr: assert property (p_badadr) else $error("bad fetch not reset");

	property p_data_ok;
		run && UNMAPPED_ADDR_I && !OPCODE_FETCH_I && !hold_c && !pulse_c && !STOP_EXEC_I |=> INTERNAL_RESET_N_O;
	endproperty
	a_data_ok: assert property (p_data_ok) else $error("data access caused reset");

	property p_erased;
		erased && !hold_c && !POWER_ON_PULSE_I |=> FORCE_MONITOR_O && !INTERNAL_RESET_N_O;
	endproperty
	a_erased: assert property (p_erased) else $error("erased vector not handled");

	property p_lv;
		lv_trip && !POWER_ON_PULSE_I |=> q.state == ST_HOLD && q.cause[`RSS_B_LV] && q.long_f;
	endproperty
	a_lv: assert property (p_lv) else $error("low voltage not held");

	property p_count;
		q.state inside {ST_LONG, ST_SREC} && !hold_c && !pulse_c |=> q.cnt == 12'($past(q.cnt) + 12'h001);
	endproperty
	a_count: assert property (p_count) else $error("counter did not advance");

	property p_stop_rec;
		$rose(q.state == ST_RUN) && hlp_k == 2'h2 |->
			hlp_n == (q.opt[`RSS_O_SHORT_STOP_RECOVERY] ? 13'(`RSS_SSTOP_CYC) : 13'(`RSS_LONG_CYC));
	endproperty
	a_stop_rec: assert property (p_stop_rec) else $error("stop recovery length wrong");

	property p_free;
		run && q.cnt != TICK_LAST && !svc && !hold_c && !pulse_c && !STOP_EXEC_I |=>
			q.cnt == 12'($past(q.cnt) + 12'h001);
	endproperty
	a_free: assert property (p_free) else $error("counter not free running");

	property p_c_por;
		$rose(INTERNAL_RESET_N_O) && hlp_k == 2'h1;
	endproperty
	c_por: cover property (p_c_por);

	property p_c_wd;
		wd_ovf;
	endproperty
	c_wd: cover property (p_c_wd);

	property p_c_sstop;
		$rose(q.state == ST_RUN) && hlp_k == 2'h2 && q.opt[`RSS_O_SHORT_STOP_RECOVERY];
	endproperty
	c_sstop: cover property (p_c_sstop);

	property p_c_erased;
		erased ##1 FORCE_MONITOR_O;
	endproperty
	c_erased: cover property (p_c_erased);

endmodule : rss_reset_sequencer

// ===== sim/rss_cpu_model.sv
// CPU-side event model driving decode and fetch inputs of the sequencer
`timescale 1ns/10ps
module rss_cpu_model (
	input  wire logic       clk_i,
	output logic            bad_op_o,
	output logic            stop_o,
	output logic            wake_o,
	output logic            fetch_o,
	output logic            unmap_o,
	output logic            vfetch_o,
	output logic      [7:0] vdata_o
);
	initial begin
		{bad_op_o, stop_o, wake_o, fetch_o, unmap_o, vfetch_o} = 6'h0;
		vdata_o = 8'hff;
	end
	// Kinds: 0 bad op, 1 stop, 2 wake, 3 opcode fetch, 4 data access, 5 vector byte
	task automatic ev(input int k, input logic [7:0] d);
		@(posedge clk_i);
		case (k)
			0: bad_op_o <= 1'h1;
			1: stop_o <= 1'h1;
			2: wake_o <= 1'h1;
			3: {fetch_o, unmap_o} <= 2'h3;
			4: unmap_o <= 1'h1;
			default: {vfetch_o, vdata_o} <= {1'h1, d};
		endcase
		@(posedge clk_i);
		{bad_op_o, stop_o, wake_o, fetch_o, unmap_o, vfetch_o} <= 6'h0;
		// Released byte must not keep looking like valid data
		vdata_o <= ~d;
	endtask : ev
endmodule : rss_cpu_model

// ===== sim/tb_top.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
	import rss_pkg::*;
	localparam int WDT = 2;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        por = 1'h0, ext_n = 1'h1, lv = 1'h0, mon = 1'h0, hv = 1'h0, wr = 1'h0, rd = 1'h0;
	logic [15:0] addr = 16'h0, vec;
	logic [7:0]  wdata = 8'h0, rdata, dat, a0, vd, exp_c;
	logic        internal_reset_n_n, cpu_en, cg_en, fmon, bad_op, stp, wake, fch, unm, vf;
	int          n_errors = 0, n_tests = 0, n;
	int          kinds[4] = '{0, 3, 1, 5};
	logic [7:0]  bits[4] = '{8'h10, 8'h08, 8'h10, 8'h04};

	always #2.5 clk = ~clk;

	rss_reset_sequencer #(.WD_TICKS(WDT)) dut_u (
		.REF_CLK_I(clk), .RESETN_I(rst_n), .POWER_ON_PULSE_I(por), .EXT_RESET_N_I(ext_n),
		.LOW_VOLTAGE_I(lv), .ILLEGAL_OPCODE_I(bad_op), .STOP_EXEC_I(stp), .WAKE_I(wake),
		.OPCODE_FETCH_I(fch), .UNMAPPED_ADDR_I(unm), .VECTOR_FETCH_I(vf), .VECTOR_DATA_I(vd),
		.MONITOR_MODE_I(mon), .IRQ_HIGH_VOLTAGE_I(hv), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .INTERNAL_RESET_N_O(internal_reset_n_n), .CPU_CLK_EN_O(cpu_en),
		.CLOCK_GENERATOR_OUTPUT_EN_O(cg_en), .RESET_VECTOR_O(vec), .FORCE_MONITOR_O(fmon)
	);

	rss_cpu_model cpu_u (
		.clk_i(clk), .bad_op_o(bad_op), .stop_o(stp), .wake_o(wake), .fetch_o(fch),
		.unmap_o(unm), .vfetch_o(vf), .vdata_o(vd)
	);

	task automatic results;
		$display("Checks %0d, errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		{wr, addr, wdata} <= {1'h1, a, d};
		@(posedge clk);
		wr <= 1'h0;
	endtask : wr_reg

	// Data were registered at the falling edge in between
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		{rd, addr} <= {1'h1, a};
		@(posedge clk);
		rd <= 1'h0;
		d = rdata;
	endtask : rd_reg

	task automatic cc(input logic [7:0] e);
		rd_reg(16'hfe00, dat);
		`CHK(dat, e)
	endtask : cc

	// Counts falling edges until the watched output reaches lvl; lim+1 if never
	task automatic wt(input logic which, input logic lvl, input int lim, input logic must, output int k);
		for (k = 1; k <= lim; k++) begin
			@(negedge clk);
			#1;
			if ((which ? cpu_en : internal_reset_n_n) === lvl) return;
		end
		if (must) begin
			n_errors++;
			$display("[ERR] %0t wait ran out", $time);
			results();
		end
	endtask : wt

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		@(negedge clk);
		#1;
		`CHK({cg_en, internal_reset_n_n}, 2'h2)
		wt(1, 1, 5000, 1, n);
		`CHK(n, 4096)
		wt(0, 1, 200, 1, n);
		`CHK(n, 67)
		// Block reset is not a power-on pulse: cause register starts empty
		exp_c = 8'h00;
		cc(exp_c);
		`CHK(vec, 16'hfffe)
		wr_reg(16'hfe01, 8'hff);
		rd_reg(16'hfe01, dat);
		`CHK(dat, 8'h0f)
		wr_reg(16'hfe00, 8'h55);
		cc(exp_c);
		rd_reg(16'hfe04, dat);
		`CHK(dat, 8'h00)
		rd_reg(16'hfe02, a0);
		rd_reg(16'hfe02, dat);
		`CHK(8'(dat - a0), 8'h02)
		wr_reg(16'hffff, 8'h00);
		rd_reg(16'hfe03, dat);
		`CHK(dat, 8'hc0)
		cpu_u.ev(4, 8'h00);
		wt(0, 0, 5, 0, n);
		`CHK(n, 6)
		cpu_u.ev(5, 8'h5a);
		wt(0, 0, 5, 0, n);
		`CHK(n, 6)
		foreach (kinds[i]) begin
			cpu_u.ev(kinds[i], 8'h00);
			`CHK(internal_reset_n_n, 1'h0)
			wt(0, 1, 200, 1, n);
			`CHK(n, 67)
			exp_c |= bits[i];
			cc(exp_c);
		end
		`CHK({fmon, vec}, {1'h1, 16'hfefe})
		for (int s = 0; s < 2; s++) begin
			wr_reg(16'hfe01, s ? 8'h03 : 8'h01);
			cpu_u.ev(1, 8'h00);
			`CHK({internal_reset_n_n, cpu_en}, 2'h2)
			cpu_u.ev(2, 8'h00);
			wt(1, 1, 5000, 1, n);
			`CHK(n, s ? 32 : 4096)
		end
		// Too short to qualify: pin flag stays clear
		@(posedge clk);
		ext_n <= 1'h0;
		repeat (3) @(posedge clk);
		ext_n <= 1'h1;
		repeat (4) @(posedge clk);
		wt(0, 1, 200, 1, n);
		cc(exp_c);
		ext_n <= 1'h0;
		repeat (20) @(posedge clk);
		`CHK(internal_reset_n_n, 1'h0)
		ext_n <= 1'h1;
		wt(0, 1, 200, 1, n);
		`CHK(n >= 68 && n <= 72, 1'h1)
		exp_c |= 8'h40;
		cc(exp_c);
		for (int m = 0; m < 3; m++) begin
			wr_reg(16'hfe01, m < 2 ? 8'h04 << m : 8'h00);
			lv <= 1'h1;
			repeat (10) @(posedge clk);
			`CHK(internal_reset_n_n, m < 2 ? 1'h1 : 1'h0)
			lv <= 1'h0;
		end
		wt(0, 1, 5000, 1, n);
		`CHK(n, 4164)
		exp_c |= 8'h02;
		cc(exp_c);
		wr_reg(16'hffff, 8'h00);
		wt(0, 0, 9000, 1, n);
		`CHK(n >= 4080 * WDT - 40 && n <= 4080 * WDT + 5, 1'h1)
		wt(0, 1, 200, 1, n);
		exp_c |= 8'h20;
		cc(exp_c);
		{mon, hv} <= 2'h3;
		wr_reg(16'hffff, 8'h00);
		wt(0, 0, 9000, 0, n);
		`CHK(n, 9001)
		`CHK(vec, 16'hfefe)
		@(posedge clk);
		{mon, hv, por} <= 3'h1;
		repeat (5) @(posedge clk);
		por <= 1'h0;
		wt(0, 1, 5000, 1, n);
		`CHK(n, 4164)
		cc(8'h80);
		`CHK(fmon, 1'h0)
		results();
	end
endmodule : tb_top
